// ===== core/cpuso_defs.svh
// Constants for the special and transfer instruction core
`ifndef CPUSO_DEFS_SVH
`define CPUSO_DEFS_SVH
`define CPUSO_OP_NOP 8'h00
`define CPUSO_OP_UNSIGNED_MULTIPLY 8'h01
`define CPUSO_OP_UNSIGNED_DIVIDE 8'h11
`define CPUSO_OP_LD_IMM 8'h04
`define CPUSO_OP_LD_DIR 8'h05
`define CPUSO_OP_LD_IDX 8'h06
`define CPUSO_OP_LD_EP 8'h07
`define CPUSO_OP_LD_EXT 8'h60
`define CPUSO_OP_LD_AT_A 8'h92
`define CPUSO_OP_ST_DIR 8'h45
`define CPUSO_OP_ST_IDX 8'h46
`define CPUSO_OP_ST_EP 8'h47
`define CPUSO_OP_ST_EXT 8'h61
`define CPUSO_OP_MI_DIR 8'h85
`define CPUSO_OP_MI_IDX 8'h86
`define CPUSO_OP_MI_EP 8'h87
`define CPUSO_OP_JUMP_VIA_ACC 8'hE0
`define CPUSO_OP_PC_TO_A 8'hF0
`define CPUSO_OP_XCH_PC 8'hF4
`define CPUSO_HI5_LD_RI 5'h01
`define CPUSO_HI5_ST_RI 5'h09
`define CPUSO_HI5_MI_RI 5'h11
`define CPUSO_HI5_BIT_CLEAR_OP 5'h14
`define CPUSO_HI5_BIT_SET_OP 5'h15
`define CPUSO_HI5_VECTOR_CALL 5'h1D
`define CPUSO_VEC_BASE 16'hFFC0
`define CPUSO_RI_PAGE 8'h01
`define CPUSO_DIR_PAGE 8'h00
`define CPUSO_RESET_PC 16'h0000
`define CPUSO_RESET_SP 16'h0000
`endif

// ===== core/cpuso_pkg.sv
// Types for the special and transfer instruction core
package cpuso_pkg;
   typedef enum logic [8:0] {
      ST_FETCH = 9'h001,
      ST_OPND1 = 9'h002,
      ST_OPND2 = 9'h004,
      ST_MEMRD = 9'h008,
      ST_MEMWR = 9'h010,
      ST_PUSH = 9'h020,
      ST_VECHI = 9'h040,
      ST_VECLO = 9'h080,
      ST_MATH = 9'h100
   } cpuso_state_t;
endpackage

// ===== core/cpuso_core.sv
// Instruction sequencer for special, bit and byte transfer instructions
// Function
// - Inherent opcodes act with no operand fetch
// - Jump via accumulator loads counter from accumulator
// - Capture stores next opcode address in accumulator
// - Multiply low bytes into accumulator, flags kept
// - Divide temp by low byte, quotient and remainder
// - Divide overflow undefined, flags unchanged
// - Swap branches and keeps next address
// - Vector call pushes return, jumps through table
// - Vector call is one byte, returns next
// - Vector entries two bytes, high first, from FFC0
// - Bit ops read byte, change bit, write back
// - Bit ops take four cycles with READ_MODIFY_WRITE_FLAG read
// - Clear at A0, set at A8, bit by opcode
// - Bit address is direct byte, page zero
// - Ports return latch during READ_MODIFY_WRITE_FLAG read
// - Interrupt flag bit 0 reads one during READ_MODIFY_WRITE_FLAG
// - Accumulator byte stores change no flags
// - Byte loads set N,Z and copy low byte
// - Only low accumulator byte goes to temp
`timescale 1ns/100ps
`include "cpuso_defs.svh"
module cpuso_core #(
   parameter int MUL_CYCLES = 17,
   parameter int DIV_CYCLES = 19
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Memory bus
   output logic [15:0] busAddr,
   output logic busRd,
   output logic busWr,
   output logic [7:0] busWdata,
   output logic readModifyWriteFlag,
   input wire logic [7:0] busRdata,
   // Register bank pointer and architectural state view
   input wire logic [4:0] regBankPtr,
   output logic [15:0] accOut,
   output logic [15:0] tempOut,
   output logic [15:0] pcOut,
   output logic [15:0] spOut,
   output logic flagN,
   output logic flagZ
);
   cpuso_pkg::cpuso_state_t state_q, state_d;
   logic [15:0] pc_q, acc_q, temp_q, sp_q, ix_q, ep_q;
   logic [7:0] op_q, opnd_q, vecHi_q;
   logic [15:0] busAddr_q;
   logic busRd_q, busWr_q, rmw_q;
   logic [7:0] busWdata_q;
   logic n_q, z_q;
   logic [4:0] cnt_q;
   logic secondOp_q;
   wire logic [15:0] pcNext = pc_q + 16'h0001;
   wire logic [4:0] opHi = op_q[7:3];
   wire logic [4:0] rdHi = busRdata[7:3];
   wire logic isLd = (op_q == `CPUSO_OP_LD_IMM) || (op_q == `CPUSO_OP_LD_DIR) ||
      (op_q == `CPUSO_OP_LD_IDX) || (op_q == `CPUSO_OP_LD_EP) || (op_q == `CPUSO_OP_LD_EXT) ||
      (op_q == `CPUSO_OP_LD_AT_A) || (opHi == `CPUSO_HI5_LD_RI);
   wire logic isSt = (op_q == `CPUSO_OP_ST_DIR) || (op_q == `CPUSO_OP_ST_IDX) ||
      (op_q == `CPUSO_OP_ST_EP) || (op_q == `CPUSO_OP_ST_EXT) || (opHi == `CPUSO_HI5_ST_RI);
   wire logic isMi = (op_q == `CPUSO_OP_MI_DIR) || (op_q == `CPUSO_OP_MI_IDX) ||
      (op_q == `CPUSO_OP_MI_EP) || (opHi == `CPUSO_HI5_MI_RI);
   wire logic isBit = (opHi == `CPUSO_HI5_BIT_CLEAR_OP) || (opHi == `CPUSO_HI5_BIT_SET_OP);
   // Zero-operand memory opcodes; any other unlisted opcode is a one-cycle no-op
   wire logic rdStore = (busRdata == `CPUSO_OP_ST_EP) || (rdHi == `CPUSO_HI5_ST_RI);
   wire logic rdLoad = (busRdata == `CPUSO_OP_LD_EP) || (busRdata == `CPUSO_OP_LD_AT_A) ||
      (rdHi == `CPUSO_HI5_LD_RI);
   wire logic [15:0] riAddr = {`CPUSO_RI_PAGE, regBankPtr, op_q[2:0]};
   wire logic [15:0] prod = {8'h00, acc_q[7:0]} * {8'h00, temp_q[7:0]};
   wire logic [15:0] divQ = (acc_q[7:0] == 8'h00) ? 16'hFFFF : temp_q / {8'h00, acc_q[7:0]};
   wire logic [15:0] divR = (acc_q[7:0] == 8'h00) ? temp_q : temp_q % {8'h00, acc_q[7:0]};
   wire logic [7:0] bitMask = 8'h01 << op_q[2:0];
   wire logic [7:0] bitNew = (opHi == `CPUSO_HI5_BIT_SET_OP) ? (busRdata | bitMask) :
      (busRdata & ~bitMask);
   // Data address of a load or store whose operand bytes are in hand
   function automatic logic [15:0] dataAddr(input logic [7:0] op, input logic [7:0] o1,
                                            input logic [7:0] o2, input logic [15:0] ri);
      logic [15:0] a;
      a = ri;
      if (op[2:0] == 3'h5) a = {`CPUSO_DIR_PAGE, o1};
      else if (op[2:0] == 3'h6) a = ix_q + {{8{o1[7]}}, o1};
      else if (op[2:0] == 3'h7) a = ep_q;
      else if (op == `CPUSO_OP_LD_EXT || op == `CPUSO_OP_ST_EXT) a = {o1, o2};
      else if (op == `CPUSO_OP_LD_AT_A) a = acc_q;
      return a;
   endfunction
   // Operand bytes needed after the opcode
   function automatic logic [1:0] opndCount(input logic [7:0] op);
      logic [1:0] n;
      n = 2'd0;
      if (op == `CPUSO_OP_LD_EXT || op == `CPUSO_OP_ST_EXT) n = 2'd2;
      else if (op == `CPUSO_OP_MI_DIR || op == `CPUSO_OP_MI_IDX) n = 2'd2;
      else if (op == `CPUSO_OP_MI_EP || op[7:3] == `CPUSO_HI5_MI_RI) n = 2'd1;
      else if (op == `CPUSO_OP_LD_IMM || op == `CPUSO_OP_LD_DIR || op == `CPUSO_OP_LD_IDX) n = 2'd1;
      else if (op == `CPUSO_OP_ST_DIR || op == `CPUSO_OP_ST_IDX) n = 2'd1;
      else if (op[7:3] == `CPUSO_HI5_BIT_CLEAR_OP || op[7:3] == `CPUSO_HI5_BIT_SET_OP) n = 2'd1;
      return n;
   endfunction
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         state_q <= cpuso_pkg::ST_FETCH;
         pc_q <= `CPUSO_RESET_PC;
         sp_q <= `CPUSO_RESET_SP;
         acc_q <= 16'h0000;
         temp_q <= 16'h0000;
         ix_q <= 16'h0000;
         ep_q <= 16'h0000;
         op_q <= 8'h00;
         opnd_q <= 8'h00;
         vecHi_q <= 8'h00;
         busAddr_q <= `CPUSO_RESET_PC;
         busRd_q <= 1'b1;
         busWr_q <= 1'b0;
         busWdata_q <= 8'h00;
         rmw_q <= 1'b0;
         n_q <= 1'b0;
         z_q <= 1'b0;
         cnt_q <= 5'h00;
         secondOp_q <= 1'b0;
      end else begin
         state_q <= state_d;
         busRd_q <= 1'b1;
         busWr_q <= 1'b0;
         rmw_q <= 1'b0;
         unique case (state_q)
            cpuso_pkg::ST_FETCH: begin
               op_q <= busRdata;
               secondOp_q <= 1'b0;
               pc_q <= pcNext;
               busAddr_q <= pcNext;
               if (busRdata == `CPUSO_OP_JUMP_VIA_ACC) begin
                  pc_q <= acc_q;
                  busAddr_q <= acc_q;
               end else if (busRdata == `CPUSO_OP_PC_TO_A) begin
                  acc_q <= pcNext;
               end else if (busRdata == `CPUSO_OP_XCH_PC) begin
                  acc_q <= pcNext;
                  pc_q <= acc_q;
                  busAddr_q <= acc_q;
               end else if (busRdata == `CPUSO_OP_UNSIGNED_MULTIPLY || busRdata == `CPUSO_OP_UNSIGNED_DIVIDE) begin
                  cnt_q <= (busRdata == `CPUSO_OP_UNSIGNED_MULTIPLY) ? MUL_CYCLES[4:0] : DIV_CYCLES[4:0];
               end else if (rdHi == `CPUSO_HI5_VECTOR_CALL) begin
                  busAddr_q <= sp_q - 16'h0001;
                  busWdata_q <= pcNext[7:0];
                  busRd_q <= 1'b0;
                  busWr_q <= 1'b1;
                  sp_q <= sp_q - 16'h0001;
               end else if (rdStore || rdLoad) begin
                  busAddr_q <= dataAddr(busRdata, 8'h00, 8'h00,
                     {`CPUSO_RI_PAGE, regBankPtr, busRdata[2:0]});
                  busWdata_q <= acc_q[7:0];
                  busRd_q <= ~rdStore;
                  busWr_q <= rdStore;
               end
            end
            cpuso_pkg::ST_OPND1, cpuso_pkg::ST_OPND2: begin
               opnd_q <= busRdata;
               pc_q <= pcNext;
               busAddr_q <= pcNext;
               secondOp_q <= 1'b1;
               if (state_q == cpuso_pkg::ST_OPND1 && isBit) begin
                  busAddr_q <= {`CPUSO_DIR_PAGE, busRdata};
                  rmw_q <= 1'b1;
               end else if (state_q == cpuso_pkg::ST_OPND1 && op_q == `CPUSO_OP_LD_IMM) begin
                  temp_q[7:0] <= acc_q[7:0];
                  acc_q[7:0] <= busRdata;
                  n_q <= busRdata[7];
                  z_q <= (busRdata == 8'h00);
               end else if (state_q == cpuso_pkg::ST_OPND1 && isMi && opndCount(op_q) == 2'd2) begin
                  busAddr_q <= pcNext;
               end else if (isMi) begin
                  busAddr_q <= dataAddr({5'h00, op_q[2:0]}, opnd_q, 8'h00, riAddr);
                  if (op_q[2:0] == 3'h5 || op_q[2:0] == 3'h6)
                     busAddr_q <= dataAddr(op_q, opnd_q, 8'h00, riAddr);
                  busWdata_q <= busRdata;
                  busRd_q <= 1'b0;
                  busWr_q <= 1'b1;
               end else if (state_q == cpuso_pkg::ST_OPND1 && opndCount(op_q) == 2'd2) begin
                  busAddr_q <= pcNext;
               end else begin
                  busAddr_q <= (state_q == cpuso_pkg::ST_OPND2) ?
                     dataAddr(op_q, opnd_q, busRdata, riAddr) :
                     dataAddr(op_q, busRdata, 8'h00, riAddr);
                  busWdata_q <= acc_q[7:0];
                  busRd_q <= ~isSt;
                  busWr_q <= isSt;
               end
            end
            cpuso_pkg::ST_MEMRD: begin
               busAddr_q <= pc_q;
               if (isBit) begin
                  busAddr_q <= busAddr_q;
                  busWdata_q <= bitNew;
                  busRd_q <= 1'b0;
                  busWr_q <= 1'b1;
               end else begin
                  temp_q[7:0] <= acc_q[7:0];
                  acc_q[7:0] <= busRdata;
                  n_q <= busRdata[7];
                  z_q <= (busRdata == 8'h00);
               end
            end
            cpuso_pkg::ST_MEMWR: begin
               busAddr_q <= pc_q;
            end
            cpuso_pkg::ST_PUSH: begin
               // First pass writes the high return byte, second pass starts the table read
               secondOp_q <= 1'b1;
               busAddr_q <= sp_q - 16'h0001;
               busWdata_q <= pc_q[15:8];
               busRd_q <= 1'b0;
               busWr_q <= 1'b1;
               sp_q <= sp_q - 16'h0001;
               if (secondOp_q) begin
                  busAddr_q <= `CPUSO_VEC_BASE + {12'h000, op_q[2:0], 1'b0};
                  busRd_q <= 1'b1;
                  busWr_q <= 1'b0;
                  sp_q <= sp_q;
               end
            end
            cpuso_pkg::ST_VECHI: begin
               vecHi_q <= busRdata;
               busAddr_q <= busAddr_q + 16'h0001;
            end
            cpuso_pkg::ST_VECLO: begin
               pc_q <= {vecHi_q, busRdata};
               busAddr_q <= {vecHi_q, busRdata};
            end
            cpuso_pkg::ST_MATH: begin
               busAddr_q <= pc_q;
               if (cnt_q != 5'h00) begin
                  cnt_q <= cnt_q - 5'h01;
               end else if (op_q == `CPUSO_OP_UNSIGNED_MULTIPLY) begin
                  acc_q <= prod;
               end else begin
                  acc_q <= {8'h00, divQ[7:0]};
                  temp_q <= {8'h00, divR[7:0]};
               end
            end
         endcase
      end
   end
   // Next state
   always_comb begin
      state_d = cpuso_pkg::ST_FETCH;
      unique case (state_q)
         cpuso_pkg::ST_FETCH: begin
            if (rdHi == `CPUSO_HI5_VECTOR_CALL)
               state_d = cpuso_pkg::ST_PUSH;
            else if (busRdata == `CPUSO_OP_UNSIGNED_MULTIPLY || busRdata == `CPUSO_OP_UNSIGNED_DIVIDE)
               state_d = cpuso_pkg::ST_MATH;
            else if (opndCount(busRdata) != 2'd0)
               state_d = cpuso_pkg::ST_OPND1;
            else if (busRdata == `CPUSO_OP_NOP || busRdata == `CPUSO_OP_JUMP_VIA_ACC ||
                     busRdata == `CPUSO_OP_PC_TO_A || busRdata == `CPUSO_OP_XCH_PC)
               state_d = cpuso_pkg::ST_FETCH;
            else if (rdStore)
               state_d = cpuso_pkg::ST_MEMWR;
            else if (rdLoad)
               state_d = cpuso_pkg::ST_MEMRD;
            else
               state_d = cpuso_pkg::ST_FETCH;
         end
         cpuso_pkg::ST_OPND1: begin
            if (isBit)
               state_d = cpuso_pkg::ST_MEMRD;
            else if (op_q == `CPUSO_OP_LD_IMM)
               state_d = cpuso_pkg::ST_FETCH;
            else if (opndCount(op_q) == 2'd2)
               state_d = cpuso_pkg::ST_OPND2;
            else if (isSt || isMi)
               state_d = cpuso_pkg::ST_MEMWR;
            else
               state_d = cpuso_pkg::ST_MEMRD;
         end
         cpuso_pkg::ST_OPND2: state_d = (isLd) ? cpuso_pkg::ST_MEMRD : cpuso_pkg::ST_MEMWR;
         cpuso_pkg::ST_MEMRD: state_d = isBit ? cpuso_pkg::ST_MEMWR : cpuso_pkg::ST_FETCH;
         cpuso_pkg::ST_MEMWR: state_d = cpuso_pkg::ST_FETCH;
         cpuso_pkg::ST_PUSH: state_d = secondOp_q ? cpuso_pkg::ST_VECHI : cpuso_pkg::ST_PUSH;
         cpuso_pkg::ST_VECHI: state_d = cpuso_pkg::ST_VECLO;
         cpuso_pkg::ST_VECLO: state_d = cpuso_pkg::ST_FETCH;
         cpuso_pkg::ST_MATH: state_d = (cnt_q == 5'h00) ? cpuso_pkg::ST_FETCH :
            cpuso_pkg::ST_MATH;
      endcase
   end
   assign busAddr = busAddr_q;
   assign busRd = busRd_q;
   assign busWr = busWr_q;
   assign busWdata = busWdata_q;
   assign readModifyWriteFlag = rmw_q;
   assign accOut = acc_q;
   assign tempOut = temp_q;
   assign pcOut = pc_q;
   assign spOut = sp_q;
   assign flagN = n_q;
   assign flagZ = z_q;
endmodule // cpuso_core

// ===== verif/cpuso_core_chk.sv
// Bus sequence checker for the instruction core
`timescale 1ns/100ps
module cpuso_core_chk #(
   parameter int MUL_CYCLES = 17,
   parameter int DIV_CYCLES = 19
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Memory bus
   input wire logic [15:0] busAddr,
   input wire logic busRd,
   input wire logic busWr,
   input wire logic [7:0] busWdata,
   input wire logic readModifyWriteFlag,
   input wire logic [7:0] busRdata,
   // State view
   input wire logic [15:0] pcOut,
   input wire logic flagN,
   input wire logic flagZ
);
   sequence rmwRead;
      readModifyWriteFlag && busRd && !busWr;
   endsequence
   sequence wrCycle;
      busWr && !busRd;
   endsequence
   chk_rmw_direct_page: assert property (@(posedge clk_sys) disable iff (!rstn)
      readModifyWriteFlag |-> busRd && !busWr && busAddr[15:8] == 8'h00)
      else $error("modify read outside direct page");
   chk_rmw_write_back: assert property (@(posedge clk_sys) disable iff (!rstn)
      rmwRead |=> busWr && !busRd && !readModifyWriteFlag && busAddr == $past(busAddr))
      else $error("modified byte not written to read address");
   chk_rmw_one_bit: assert property (@(posedge clk_sys) disable iff (!rstn)
      rmwRead ##1 wrCycle |-> $countones(busWdata ^ $past(busRdata)) <= 1)
      else $error("write back changed more than one bit");
   chk_rmw_next_fetch: assert property (@(posedge clk_sys) disable iff (!rstn)
      rmwRead ##1 wrCycle |=> busRd && busAddr == $past(busAddr, 3) + 16'h0001)
      else $error("fetch after bit op not at opcode plus two");
   chk_rmw_single_read: assert property (@(posedge clk_sys) disable iff (!rstn)
      readModifyWriteFlag |=> !readModifyWriteFlag)
      else $error("modify flag held past one cycle");
   chk_push_pair: assert property (@(posedge clk_sys) disable iff (!rstn)
      wrCycle ##1 wrCycle |-> busAddr == $past(busAddr) - 16'h0001)
      else $error("second push not below first");
   chk_vec_after_push: assert property (@(posedge clk_sys) disable iff (!rstn)
      wrCycle ##1 wrCycle |=> busRd && busAddr[15:4] == 12'hFFC && !busAddr[0])
      else $error("push not followed by vector entry read");
   chk_vec_high_low: assert property (@(posedge clk_sys) disable iff (!rstn)
      busRd && $past(busWr) && busAddr[15:4] == 12'hFFC && !busAddr[0]
      |=> busRd && busAddr == $past(busAddr) + 16'h0001)
      else $error("vector low byte not read after high byte");
   chk_flags_on_write: assert property (@(posedge clk_sys) disable iff (!rstn)
      busWr |=> $stable(flagN) && $stable(flagZ))
      else $error("flags changed by a store");
   chk_reset_bus: assert property (@(posedge clk_sys)
      !rstn |=> busAddr == 16'h0000 && busRd && !busWr && !readModifyWriteFlag && pcOut == 16'h0000)
      else $error("bus not idle at reset");
endmodule // cpuso_core_chk

// ===== verif/cpuso_mem.sv
// Memory and peripheral register model on the core bus
`timescale 1ns/100ps
module cpuso_mem #(
   parameter logic [15:0] PORT_ADDR = 16'h00F0,
   parameter logic [15:0] FLAG_ADDR = 16'h00F1
) (
   // Clock
   input wire logic clk_sys,
   // Core bus
   input wire logic [15:0] busAddr,
   input wire logic busRd,
   input wire logic busWr,
   input wire logic [7:0] busWdata,
   input wire logic readModifyWriteFlag,
   output logic [7:0] busRdata,
   // Port pin levels
   input wire logic [7:0] portPins
);
   logic [7:0] memArr [65536];
   logic [7:0] portLatch;
   logic [7:0] flagReg;
   logic [7:0] flagWr;
   logic [7:0] lastQ = 8'h00;
   logic [7:0] rdVal;
   // Alternate values chosen by the modify flag in the read cycle
   assign rdVal = (busAddr == PORT_ADDR) ? (readModifyWriteFlag ? portLatch : portPins) :
      (busAddr == FLAG_ADDR) ? (flagReg | {7'h00, readModifyWriteFlag}) :
      memArr[busAddr];
   // Released bus shows the inverse of the last byte
   assign busRdata = busRd ? rdVal : ~lastQ;
   always @(posedge clk_sys) begin
      if (busRd) begin
         lastQ <= rdVal;
      end
      if (busWr) begin
         if (busAddr == PORT_ADDR) begin
            portLatch <= busWdata;
         end else if (busAddr == FLAG_ADDR) begin
            // Writing one leaves a pending request alone
            flagReg <= {busWdata[7:1], busWdata[0] & flagReg[0]};
            flagWr <= busWdata;
         end else begin
            memArr[busAddr] <= busWdata;
         end
      end
   end
endmodule // cpuso_mem

// ===== verif/cpu_special_and_transfer_ops_tb_top.sv
// Self-checking bench for the special and transfer instruction core
`timescale 1ns/100ps
module cpu_special_and_transfer_ops_tb_top;
   typedef struct packed {
      logic [95:0] prog;
      logic [15:0] acc;
      logic [15:0] temp;
      logic n;
      logic z;
   } cpuso_row_t;
   logic clk_sys, rstn, busRd, busWr, readModifyWriteFlag, flagN, flagZ;
   logic [15:0] busAddr, accOut, tempOut, pcOut, spOut;
   logic [7:0] busWdata, busRdata, portPins, expB;
   logic [4:0] regBankPtr;
   int numErrors, nChecks;
   cpuso_row_t rows [11];
   logic [23:0] pokes [11] = '{24'h0030F0, 24'h003104, 24'h003240, 24'h0033F4, 24'h0040EB,
      24'hFFC600, 24'hFFC750, 24'h005045, 24'h005160, 24'h0052F0, 24'hFFFE55};
   cpuso_core #(.MUL_CYCLES(3), .DIV_CYCLES(4)) dut_u (.clk_sys(clk_sys), .rstn(rstn),
      .busAddr(busAddr), .busRd(busRd), .busWr(busWr), .busWdata(busWdata),
      .readModifyWriteFlag(readModifyWriteFlag), .busRdata(busRdata), .regBankPtr(regBankPtr),
      .accOut(accOut), .tempOut(tempOut), .pcOut(pcOut), .spOut(spOut), .flagN(flagN),
      .flagZ(flagZ));
   cpuso_mem mem_u (.clk_sys(clk_sys), .busAddr(busAddr), .busRd(busRd), .busWr(busWr),
      .busWdata(busWdata), .readModifyWriteFlag(readModifyWriteFlag), .busRdata(busRdata),
      .portPins(portPins));
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   task automatic compare(input string what, input logic [15:0] exp, input logic [15:0] got);
      nChecks++;
      if (got !== exp) begin
         numErrors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic endSim();
      $display("checks %0d errors %0d", nChecks, numErrors);
      if (numErrors == 0 && nChecks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Holds reset while memory is cleared and the program is placed at 0000
   task automatic load_prog(input logic [95:0] prog);
      @(negedge clk_sys);
      rstn = 1'b0;
      for (int i = 0; i < 65536; i++) mem_u.memArr[i] = 8'h00;
      for (int i = 0; i < 12; i++) mem_u.memArr[i] = prog[95 - 8 * i -: 8];
      mem_u.portLatch = 8'h81;
      mem_u.flagReg = 8'h02;
      repeat (8) @(negedge clk_sys);
   endtask
   task automatic go(input int cycles);
      rstn = 1'b1;
      repeat (cycles) @(negedge clk_sys);
   endtask
   initial begin
      #100000;
      numErrors++;
      endSim();
   end
   initial begin
      rstn = 1'b0;
      portPins = 8'h00;
      regBankPtr = 5'h02;
      numErrors = 0;
      nChecks = 0;
      rows[0] = '{{24'h000481, 72'h0}, 16'h0081, 16'h0000, 1'b1, 1'b0};
      rows[1] = '{{16'h0400, 80'h0}, 16'h0000, 16'h0000, 1'b0, 1'b1};
      rows[2] = '{{32'h04050487, 64'h0}, 16'h0087, 16'h0005, 1'b1, 1'b0};
      rows[3] = '{{40'h04F004F001, 56'h0}, 16'hE100, 16'h00F0, 1'b1, 1'b0};
      rows[4] = '{{80'h04F004F0010420040311, 16'h0}, 16'h000A, 16'h0002, 1'b0, 1'b0};
      rows[5] = '{{64'h045A45E0040005E0, 32'h0}, 16'h005A, 16'h0000, 1'b0, 1'b0};
      rows[6] = '{{48'h04A54B04000B, 48'h0}, 16'h00A5, 16'h0000, 1'b1, 1'b0};
      rows[7] = '{{64'h85E1C38A7705E10A, 32'h0}, 16'h0077, 16'h00C3, 1'b0, 1'b0};
      rows[8] = '{{32'h60000392, 64'h0}, 16'h0000, 16'h0092, 1'b0, 1'b1};
      rows[9] = '{96'h049986403C61004106400541, 16'h0099, 16'h003C, 1'b1, 1'b0};
      rows[10] = '{{48'h045C47041107, 48'h0}, 16'h005C, 16'h0011, 1'b0, 1'b0};
      repeat (8) @(negedge clk_sys);
      compare("reset addr", 16'h0000, busAddr);
      compare("reset ctl", 16'h0004, {13'h0, busRd, busWr, readModifyWriteFlag});
      foreach (rows[i]) begin
         load_prog(rows[i].prog);
         go(60);
         compare("acc", rows[i].acc, accOut);
         compare("temp", rows[i].temp, tempOut);
         compare("flags", {14'h0, rows[i].n, rows[i].z}, {14'h0, flagN, flagZ});
      end
      // Every clear and set opcode on a plain memory byte
      for (int k = 0; k < 16; k++) begin
         load_prog({8'hA0 + 8'(k), 8'hE8, 80'h0});
         mem_u.memArr[16'h00E8] = 8'h5A;
         expB = (k < 8) ? (8'h5A & ~(8'h01 << k)) : (8'h5A | (8'h01 << (k - 8)));
         go(20);
         compare("bit op", {8'h00, expB}, {8'h00, mem_u.memArr[16'h00E8]});
      end
      load_prog({32'hADF0AAF1, 64'h0});
      go(20);
      compare("port latch", 16'h00A1, {8'h00, mem_u.portLatch});
      compare("flag reg", 16'h0006, {8'h00, mem_u.flagReg});
      compare("flag write", 16'h0007, {8'h00, mem_u.flagWr});
      // Jump, capture, swap and vector call chained through memory
      load_prog({24'h0430E0, 72'h0});
      foreach (pokes[i]) mem_u.memArr[pokes[i][23:8]] = pokes[i][7:0];
      go(40);
      compare("swapped acc", 16'h0034, {8'h00, mem_u.memArr[16'h0060]});
      compare("return low", 16'h0041, {8'h00, mem_u.memArr[16'hFFFF]});
      compare("return high", 16'h0000, {8'h00, mem_u.memArr[16'hFFFE]});
      compare("stack pointer", 16'hFFFE, spOut);
      compare("final acc", 16'h0053, accOut);
      endSim();
   end
endmodule // cpu_special_and_transfer_ops_tb_top
bind cpuso_core cpuso_core_chk #(.MUL_CYCLES(MUL_CYCLES), .DIV_CYCLES(DIV_CYCLES)) chk_u (
   .clk_sys(clk_sys), .rstn(rstn), .busAddr(busAddr), .busRd(busRd), .busWr(busWr),
   .busWdata(busWdata), .readModifyWriteFlag(readModifyWriteFlag), .busRdata(busRdata),
   .pcOut(pcOut), .flagN(flagN), .flagZ(flagZ));
